// ### verilog/scc_regs.svh
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH

// serial frame layout
`define SCC_ADDR_W 15
`define SCC_HDR_LAST 4'hF
`define SCC_BYTE_LAST 4'h7
`define SCC_RW_BIT 14

// register byte addresses
`define SCC_ADDR_USR 15'h0010
`define SCC_ADDR_CLK0 15'h0029
`define SCC_ADDR_CLK1 15'h002A
`define SCC_ADDR_POS0 15'h002C
`define SCC_ADDR_POS1 15'h002D
`define SCC_ADDR_POS2 15'h002E
`define SCC_ADDR_FSA0 15'h0030
`define SCC_ADDR_FSA1 15'h0031
`define SCC_ADDR_FSB0 15'h0032
`define SCC_ADDR_FSB1 15'h0033
`define SCC_ADDR_BYP 15'h0038
`define SCC_ADDR_TMS 15'h003B

// reset values
`define SCC_RST_USR 8'h00
`define SCC_RST_CLK0 8'h00
`define SCC_RST_CLK1 8'h20
`define SCC_RST_FS 16'hA000
`define SCC_RST_BYP 8'h00
`define SCC_RST_TMS 8'h00
`define SCC_RD_UNMAPPED 8'h00

// field positions
`define SCC_USR_HOLD 0
`define SCC_CLK0_PROC 6
`define SCC_CLK0_RECV 5
`define SCC_CLK0_ZOOM 4
`define SCC_CLK0_SEL_HI 3
`define SCC_CLK0_SEL_LO 0
`define SCC_CLK1_DEVPECL 2
`define SCC_CLK1_SYNPECL 1
`define SCC_CLK1_INV 0

// capture logic
`define SCC_SEL_AUTO 4'h0
`define SCC_HIST_W 48
`define SCC_POS_W 24

`endif

// ### verilog/scc_pkg.sv
package scc_pkg;
   typedef enum logic [2:0] {
      SCC_IDLE = 3'b001,
      SCC_HDR = 3'b010,
      SCC_DATA = 3'b100
   } scc_state_e;
   typedef logic [7:0] scc_byte_t;
   typedef logic [23:0] scc_pos_t;
endpackage

// ### verilog/scc_sync_if.sv
`timescale 1ns/10ps
`default_nettype none
interface scc_sync_if;
   import scc_pkg::*;
   logic rx_en;
   logic proc_en;
   logic fine_view;
   logic invert;
   logic [3:0] delay_sel;
   scc_pos_t edge_pos;
   modport ctrl (output rx_en, proc_en, fine_view, invert, delay_sel,
      input edge_pos);
   modport capt (input rx_en, proc_en, fine_view, invert, delay_sel,
      output edge_pos);
endinterface
`default_nettype wire

// ### verilog/scc_sync_capture.sv
`timescale 1ns/10ps
`default_nettype none
`include "scc_regs.svh"
module scc_sync_capture (
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_sysref,
   scc_sync_if.capt sync,
   output logic o_event
);
   import scc_pkg::*;

   logic rx_q, rx_d, prev_q, prev_d;
   logic [`SCC_HIST_W-1:0] hist_q, hist_d;
   scc_pos_t pos_q, pos_d;
   logic [3:0] cal_q, cal_d;
   logic [15:0] dly_q, dly_d;
   logic ev_q, ev_d;
   logic edge_seen;
   logic [3:0] use_sel;

   // lowest set bit of the captured window, drives the auto delay
   function automatic logic [3:0] first_one(input logic [15:0] v);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = 15; i >= 0; i--) begin
         if (v[i]) begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction

   // sample path, capture window and delay line
   always_comb begin
      // receiver off holds the sample low, no stray edges
      rx_d = sync.rx_en & (i_sysref ^ sync.invert);
      prev_d = rx_q;
      hist_d = {hist_q[`SCC_HIST_W-2:0], rx_q};
      edge_seen = rx_q & ~prev_q & sync.proc_en;
      pos_d = pos_q;
      cal_d = cal_q;
      if (edge_seen) begin
         if (sync.fine_view) begin
            pos_d = hist_q[`SCC_POS_W-1:0];
         end else begin
            for (int k = 0; k < `SCC_POS_W; k++) begin
               pos_d[k] = hist_q[2*k]; // coarse view, every other sample
            end
         end
         cal_d = 4'hF - first_one(hist_q[15:0]);
      end
      // zero selects the self-calibrated delay
      use_sel = (sync.delay_sel == `SCC_SEL_AUTO) ? cal_q : sync.delay_sel;
      dly_d = {dly_q[14:0], edge_seen};
      ev_d = dly_q[use_sel];
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         rx_q <= 1'b0;
         prev_q <= 1'b0;
         hist_q <= '0;
         pos_q <= '0;
         cal_q <= 4'h0;
         dly_q <= 16'h0000;
         ev_q <= 1'b0;
      end else begin
         rx_q <= rx_d;
         prev_q <= prev_d;
         hist_q <= hist_d;
         pos_q <= pos_d;
         cal_q <= cal_d;
         dly_q <= dly_d;
         ev_q <= ev_d;
      end
   end

   assign sync.edge_pos = pos_q;
   assign o_event = ev_q;
endmodule
`default_nettype wire

// ### verilog/scc_regbank.sv
`timescale 1ns/10ps
`default_nettype none
`include "scc_regs.svh"
module scc_regbank (
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_scs_n,
   input wire logic i_sclk,
   input wire logic i_sdi,
   input wire logic i_addr_ascend,
   input wire logic i_sysref,
   output logic o_sdo,
   output logic o_sdo_oe_n,
   output logic o_sync_event,
   output logic o_sync_receiver_enable,
   output logic o_sync_lowv_pecl_enable,
   output logic o_device_clock_lowv_pecl_enable,
   output scc_pkg::scc_byte_t o_reference_bypass,
   output scc_pkg::scc_byte_t o_timestamp_control,
   output logic [15:0] o_full_scale_a,
   output logic [15:0] o_full_scale_b
);
   import scc_pkg::*;

   scc_sync_if sync ();

   // serial port state
   scc_state_e st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   logic [15:0] sh_q, sh_d;
   logic [`SCC_ADDR_W-1:0] addr_q, addr_d;
   logic rd_q, rd_d;
   logic sclk_q, sclk_d;
   scc_byte_t out_q, out_d;
   logic sdo_q, sdo_d;
   logic oe_n_q, oe_n_d;
   logic rise, fall;
   logic wr_en;
   logic [`SCC_ADDR_W-1:0] wr_addr, hdr_addr;
   scc_byte_t wr_data;

   // register storage
   scc_byte_t usr_q, usr_d, clk0_q, clk0_d, clk1_q, clk1_d;
   scc_byte_t byp_q, byp_d, tms_q, tms_d;
   logic [15:0] fsa_q, fsa_d, fsb_q, fsb_d;
   logic ev_w;

   // read decode, used at header end and at each byte boundary
   function automatic scc_byte_t rd_byte(input logic [`SCC_ADDR_W-1:0] a);
      scc_byte_t r;
      r = `SCC_RD_UNMAPPED;
      unique case (a)
         `SCC_ADDR_USR: r = usr_q;
         `SCC_ADDR_CLK0: r = clk0_q;
         `SCC_ADDR_CLK1: r = clk1_q;
         `SCC_ADDR_POS0: r = sync.edge_pos[7:0];
         `SCC_ADDR_POS1: r = sync.edge_pos[15:8];
         `SCC_ADDR_POS2: r = sync.edge_pos[23:16];
         `SCC_ADDR_FSA0: r = fsa_q[7:0];
         `SCC_ADDR_FSA1: r = fsa_q[15:8];
         `SCC_ADDR_FSB0: r = fsb_q[7:0];
         `SCC_ADDR_FSB1: r = fsb_q[15:8];
         `SCC_ADDR_BYP: r = byp_q;
         `SCC_ADDR_TMS: r = tms_q;
         default: r = `SCC_RD_UNMAPPED;
      endcase
      return r;
   endfunction

   // streaming address step
   function automatic logic [`SCC_ADDR_W-1:0] step(
      input logic [`SCC_ADDR_W-1:0] a);
      logic [`SCC_ADDR_W-1:0] n;
      n = a;
      if (!usr_q[`SCC_USR_HOLD]) begin
         n = i_addr_ascend ? a + 1'b1 : a - 1'b1;
      end
      return n;
   endfunction

   // serial frame: 1 direction bit, 15 address bits, then data bytes
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      addr_d = addr_q;
      rd_d = rd_q;
      out_d = out_q;
      sdo_d = sdo_q;
      oe_n_d = oe_n_q;
      sclk_d = i_sclk;
      wr_en = 1'b0;
      wr_addr = addr_q;
      wr_data = {sh_q[6:0], i_sdi};
      hdr_addr = {sh_q[13:0], i_sdi};
      rise = i_sclk & ~sclk_q;
      fall = ~i_sclk & sclk_q;
      if (i_scs_n) begin
         // deselect aborts any partial byte, nothing is written
         st_d = SCC_IDLE;
         cnt_d = 4'h0;
         oe_n_d = 1'b1;
         sdo_d = 1'b0;
      end else begin
         unique case (st_q)
            SCC_IDLE: begin
               st_d = SCC_HDR;
               cnt_d = 4'h0;
               if (rise) begin
                  sh_d = {sh_q[14:0], i_sdi};
                  cnt_d = 4'h1;
               end
            end
            SCC_HDR: begin
               if (rise) begin
                  sh_d = {sh_q[14:0], i_sdi};
                  cnt_d = cnt_q + 4'h1;
                  if (cnt_q == `SCC_HDR_LAST) begin
                     st_d = SCC_DATA;
                     cnt_d = 4'h0;
                     rd_d = sh_q[`SCC_RW_BIT];
                     addr_d = hdr_addr;
                     out_d = rd_byte(hdr_addr);
                  end
               end
            end
            SCC_DATA: begin
               if (rise) begin
                  sh_d = {sh_q[14:0], i_sdi};
                  cnt_d = cnt_q + 4'h1;
                  if (cnt_q == `SCC_BYTE_LAST) begin
                     cnt_d = 4'h0;
                     wr_en = ~rd_q;
                     addr_d = step(addr_q);
                     out_d = rd_byte(step(addr_q));
                  end
               end
               if (fall && rd_q) begin
                  // drive on the falling edge, host samples on rising
                  sdo_d = out_q[7];
                  out_d = {out_q[6:0], 1'b0};
                  oe_n_d = 1'b0;
               end
            end
            default: st_d = SCC_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         st_q <= SCC_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 16'h0000;
         addr_q <= '0;
         rd_q <= 1'b0;
         sclk_q <= 1'b0;
         out_q <= 8'h00;
         sdo_q <= 1'b0;
         oe_n_q <= 1'b1;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         addr_q <= addr_d;
         rd_q <= rd_d;
         sclk_q <= sclk_d;
         out_q <= out_d;
         sdo_q <= sdo_d;
         oe_n_q <= oe_n_d;
      end
   end

   // register writes; reserved bits are stored as written
   always_comb begin
      usr_d = usr_q;
      clk0_d = clk0_q;
      clk1_d = clk1_q;
      byp_d = byp_q;
      tms_d = tms_q;
      fsa_d = fsa_q;
      fsb_d = fsb_q;
      if (wr_en) begin
         unique case (wr_addr)
            `SCC_ADDR_USR: usr_d = wr_data;
            `SCC_ADDR_CLK0: clk0_d = wr_data;
            `SCC_ADDR_CLK1: clk1_d = wr_data;
            `SCC_ADDR_FSA0: fsa_d[7:0] = wr_data;
            `SCC_ADDR_FSA1: fsa_d[15:8] = wr_data;
            `SCC_ADDR_FSB0: fsb_d[7:0] = wr_data;
            `SCC_ADDR_FSB1: fsb_d[15:8] = wr_data;
            `SCC_ADDR_BYP: byp_d = wr_data;
            `SCC_ADDR_TMS: tms_d = wr_data;
            default: usr_d = usr_q; // read-only or unmapped, dropped
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         usr_q <= `SCC_RST_USR;
         clk0_q <= `SCC_RST_CLK0;
         clk1_q <= `SCC_RST_CLK1;
         byp_q <= `SCC_RST_BYP;
         tms_q <= `SCC_RST_TMS;
         fsa_q <= `SCC_RST_FS;
         fsb_q <= `SCC_RST_FS;
      end else begin
         usr_q <= usr_d;
         clk0_q <= clk0_d;
         clk1_q <= clk1_d;
         byp_q <= byp_d;
         tms_q <= tms_d;
         fsa_q <= fsa_d;
         fsb_q <= fsb_d;
      end
   end

   // control fields toward the capture logic
   assign sync.rx_en = clk0_q[`SCC_CLK0_RECV];
   assign sync.proc_en = clk0_q[`SCC_CLK0_PROC];
   assign sync.fine_view = clk0_q[`SCC_CLK0_ZOOM];
   assign sync.delay_sel = clk0_q[`SCC_CLK0_SEL_HI:`SCC_CLK0_SEL_LO];
   assign sync.invert = clk1_q[`SCC_CLK1_INV];

   scc_sync_capture u_capture (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_sysref(i_sysref),
      .sync(sync),
      .o_event(ev_w)
   );

   // outputs straight from flops
   assign o_sdo = sdo_q;
   assign o_sdo_oe_n = oe_n_q;
   assign o_sync_event = ev_w;
   assign o_sync_receiver_enable = clk0_q[`SCC_CLK0_RECV];
   assign o_sync_lowv_pecl_enable = clk1_q[`SCC_CLK1_SYNPECL];
   assign o_device_clock_lowv_pecl_enable = clk1_q[`SCC_CLK1_DEVPECL];
   assign o_reference_bypass = byp_q;
   assign o_timestamp_control = tms_q;
   assign o_full_scale_a = fsa_q;
   assign o_full_scale_b = fsb_q;
endmodule
`default_nettype wire

// ### tb/scc_regbank_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module scc_regbank_assertions (
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_scs_n,
   input wire logic i_sclk,
   input wire logic o_sdo,
   input wire logic o_sdo_oe_n,
   input wire logic o_sync_event,
   input wire logic o_sync_receiver_enable,
   input wire logic o_sync_lowv_pecl_enable,
   input wire logic o_device_clock_lowv_pecl_enable,
   input wire scc_pkg::scc_byte_t o_reference_bypass,
   input wire scc_pkg::scc_byte_t o_timestamp_control,
   input wire logic [15:0] o_full_scale_a,
   input wire logic [15:0] o_full_scale_b
);
   import scc_pkg::*;
   logic [4:0] off_cnt_q;
   logic [4:0] off_cnt_d;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_reset);
   // cycles with the receiver off, saturating so it never wraps
   always_comb begin
      off_cnt_d = off_cnt_q;
      if (o_sync_receiver_enable) off_cnt_d = 5'h00;
      else if (off_cnt_q != 5'h1F) off_cnt_d = off_cnt_q + 5'h01;
   end
   always_ff @(posedge i_mclk) begin
      if (i_reset) off_cnt_q <= 5'h00;
      else off_cnt_q <= off_cnt_d;
   end
   a_reset_clear: assert property (
      $fell(i_reset) |-> !o_sync_receiver_enable && o_sdo_oe_n && !o_sdo
      && !o_sync_event) else $error("outputs not cleared by reset");
   a_reset_values: assert property ($fell(i_reset) |->
      o_full_scale_a == 16'hA000 && o_full_scale_b == 16'hA000
      && o_reference_bypass == 8'h00 && o_timestamp_control == 8'h00
      && !o_sync_lowv_pecl_enable && !o_device_clock_lowv_pecl_enable)
      else $error("register outputs wrong after reset");
   // edges still in the delay line may leave shortly after switch-off
   a_receiver_off_quiet: assert property (
      o_sync_event |-> off_cnt_q < 5'h18)
      else $error("sync event while receiver off");
   a_event_one_cycle: assert property (
      o_sync_event |=> !o_sync_event) else $error("sync event too long");
   a_read_idle: assert property (
      $past(i_scs_n) && i_scs_n |-> o_sdo_oe_n)
      else $error("serial out enabled while deselected");
   a_sdo_parked: assert property (
      o_sdo_oe_n && $past(o_sdo_oe_n) |-> !o_sdo)
      else $error("serial out not parked low");
   a_cfg_write_time: assert property (
      $changed({o_full_scale_a, o_full_scale_b, o_reference_bypass,
      o_timestamp_control, o_sync_lowv_pecl_enable,
      o_device_clock_lowv_pecl_enable}) |-> $past(i_reset)
      || (!$past(i_scs_n) && $past(i_sclk)))
      else $error("register changed outside a serial write");
   a_receiver_write_time: assert property (
      $changed(o_sync_receiver_enable) |-> $past(i_reset)
      || (!$past(i_scs_n) && $past(i_sclk)))
      else $error("receiver enable changed outside a write");
endmodule
bind scc_regbank scc_regbank_assertions chk (.i_mclk, .i_reset, .i_scs_n,
   .i_sclk, .o_sdo, .o_sdo_oe_n, .o_sync_event, .o_sync_receiver_enable,
   .o_sync_lowv_pecl_enable, .o_device_clock_lowv_pecl_enable,
   .o_reference_bypass, .o_timestamp_control, .o_full_scale_a,
   .o_full_scale_b);
`default_nettype wire

// ### tb/scc_host.sv
`timescale 1ns/10ps
`default_nettype none
module scc_host (
   input wire logic i_mclk,
   input wire logic i_sdo,
   output logic o_scs_n,
   output logic o_sclk,
   output logic o_sdi
);
   logic [31:0] rd_q;
   // idle: deselected, serial clock parked low
   initial begin
      o_scs_n = 1'b1;
      o_sclk = 1'b0;
      o_sdi = 1'b0;
      rd_q = 32'h0;
   end
   // each half lasts 3 mclk, above the 2 the sampler needs
   task automatic bit_io(input logic b, output logic s);
      @(negedge i_mclk);
      o_sclk = 1'b0;
      o_sdi = b;
      repeat (3) @(negedge i_mclk);
      s = i_sdo;
      o_sclk = 1'b1;
      repeat (2) @(negedge i_mclk);
   endtask
   // one frame: direction, address, then n bytes from the top of wd
   task automatic xfer(input logic rd, input logic [14:0] a, input int n,
      input logic [31:0] wd);
      logic s;
      logic [15:0] hdr;
      hdr = {rd, a};
      @(negedge i_mclk);
      o_scs_n = 1'b0;
      for (int i = 15; i >= 0; i--) bit_io(hdr[i], s);
      for (int i = 0; i < 8 * n; i++) begin
         bit_io(wd[31-i], s);
         rd_q[31-i] = s;
      end
      @(negedge i_mclk);
      o_sclk = 1'b0;
      o_scs_n = 1'b1;
      o_sdi = ~o_sdi; // released line never keeps its last value
      repeat (2) @(negedge i_mclk);
   endtask
endmodule
`default_nettype wire

// ### tb/test_scc_regbank.sv
`timescale 1ns/10ps
`default_nettype none
module test_scc_regbank;
   import scc_pkg::*;
   logic i_mclk, i_reset, i_scs_n, i_sclk, i_sdi, i_addr_ascend, i_sysref;
   logic o_sdo, o_sdo_oe_n, o_sync_event, o_sync_receiver_enable;
   logic o_sync_lowv_pecl_enable, o_device_clock_lowv_pecl_enable;
   scc_byte_t o_reference_bypass, o_timestamp_control;
   logic [15:0] o_full_scale_a, o_full_scale_b;
   logic [23:0] pos;
   int miscompares = 0;
   int comparisons = 0;
   int c;
   scc_regbank uut (.i_mclk, .i_reset, .i_scs_n, .i_sclk, .i_sdi,
      .i_addr_ascend, .i_sysref, .o_sdo, .o_sdo_oe_n, .o_sync_event,
      .o_sync_receiver_enable, .o_sync_lowv_pecl_enable,
      .o_device_clock_lowv_pecl_enable, .o_reference_bypass,
      .o_timestamp_control, .o_full_scale_a, .o_full_scale_b);
   scc_host host (.i_mclk, .i_sdo(o_sdo), .o_scs_n(i_scs_n),
      .o_sclk(i_sclk), .o_sdi(i_sdi));
   always #12.5 i_mclk = ~i_mclk;
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [14:0] a, input int n, input logic [31:0] d);
      host.xfer(1'b0, a, n, d);
   endtask
   task automatic rd1(input logic [14:0] a, input logic [7:0] exp);
      host.xfer(1'b1, a, 1, 32'h0);
      check(host.rd_q[31:24], exp);
   endtask
   // drive the sync input, then count event pulses over a window
   task automatic sync_to(input logic lvl, input int n, output int cnt);
      cnt = 0;
      @(negedge i_mclk);
      i_sysref = lvl;
      repeat (n) begin
         @(negedge i_mclk);
         if (o_sync_event === 1'b1) cnt++;
      end
   endtask
   task automatic t_reset();
      rd1(15'h029, 8'h00);
      rd1(15'h02A, 8'h20);
      rd1(15'h010, 8'h00);
      check(o_full_scale_a, 16'hA000);
      check(o_sync_receiver_enable, 1'b0);
      $display("reset test done");
   endtask
   task automatic t_stream();
      wr(15'h030, 2, 32'h34120000);
      check(o_full_scale_a, 16'h1234);
      i_addr_ascend = 1'b0;
      wr(15'h033, 2, 32'hABCD0000);
      check(o_full_scale_b, 16'hABCD);
      i_addr_ascend = 1'b1;
      host.xfer(1'b1, 15'h030, 2, 32'h0);
      check(host.rd_q[31:16], 16'h3412);
      $display("stream test done");
   endtask
   task automatic t_hold();
      wr(15'h010, 1, 32'h01000000);
      wr(15'h030, 3, 32'h12345600);
      check(o_full_scale_a, 16'h1256);
      check(o_full_scale_b, 16'hABCD);
      wr(15'h010, 1, 32'h0);
      rd1(15'h010, 8'h00);
      $display("hold test done");
   endtask
   task automatic t_sync();
      wr(15'h029, 1, 32'h22000000);
      check(o_sync_receiver_enable, 1'b1);
      sync_to(1'b1, 40, c);
      check(c, 0);
      sync_to(1'b0, 10, c);
      wr(15'h029, 1, 32'h62000000);
      sync_to(1'b1, 40, c);
      check(c, 1);
      sync_to(1'b0, 10, c);
      check(c, 0);
      wr(15'h029, 1, 32'h60000000);
      sync_to(1'b1, 40, c);
      check(c, 1);
      sync_to(1'b0, 10, c);
      // polarity is flipped only while the processor is off
      wr(15'h029, 1, 32'h22000000);
      wr(15'h02A, 1, 32'h21000000);
      sync_to(1'b1, 30, c);
      wr(15'h029, 1, 32'h62000000);
      sync_to(1'b0, 40, c);
      check(c, 1);
      sync_to(1'b1, 40, c);
      check(c, 0);
      $display("sync test done");
   endtask
   task automatic t_status();
      host.xfer(1'b1, 15'h02C, 3, 32'h0);
      pos = host.rd_q[31:8];
      wr(15'h02C, 3, 32'hFFEEDD00);
      host.xfer(1'b1, 15'h02C, 3, 32'h0);
      check(host.rd_q[31:8], pos);
      rd1(15'h02B, 8'h00);
      wr(15'h029, 1, 32'h1F000000);
      rd1(15'h029, 8'h1F);
      check(o_sync_receiver_enable, 1'b0);
      // plain config outputs, each seen after the write to its register; both PECL enables share one write
      wr(15'h038, 1, 32'hA5000000);
      check(o_reference_bypass, 8'hA5);
      wr(15'h03B, 1, 32'h03000000);
      check(o_timestamp_control, 8'h03);
      wr(15'h02A, 1, 32'h26000000);
      check(o_sync_lowv_pecl_enable, 1'b1);
      check(o_device_clock_lowv_pecl_enable, 1'b1);
      rd1(15'h02A, 8'h26);
      // serial out released once the frame is over
      check(o_sdo_oe_n, 1'b1);
      check(o_sdo, 1'b0);
      $display("status test done");
   endtask
   task automatic close_out();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (100000) @(posedge i_mclk);
      miscompares++;
      close_out();
   end
   initial begin
      i_mclk = 1'b0;
      i_reset = 1'b1;
      i_addr_ascend = 1'b1;
      i_sysref = 1'b0;
      repeat (12) @(negedge i_mclk);
      i_reset = 1'b0;
      t_reset();
      t_stream();
      t_hold();
      t_sync();
      t_status();
      close_out();
   end
endmodule
`default_nettype wire
